// ===== hw/flash_boost_status_ctrl_regs.v
// Status and control register bank for the flash boost converter and LED driver.
//
// Functional notes
// - The link status flags register resets to zero and every bit clears when software reads it.
// - Bit 6 of link status is set when peak input current exceeds its limit and stays set until software reads it.
// - Bit 4 of link status is one when output capacitor detection failed and zero when detected.
// - A set capacitor detection error blocks new events until software reads the status register.
// - The indicator level control register is read/write and resets to zero.
// - Its lower nibble holds the indicator code n for n+1 mA and the upper nibble reads zero.
// - The soft-start threshold is eight bits read/write with reset code 0x64 (3.6 V).
// - A read-only register reports the present adaptive output voltage code, reset 0x84.
// - A read-only register reports the highest adaptive output voltage code seen, reset zero.
// - Bit 3 of the capacitor check control disables capacitor detection and resets to one.
// - Reserved bits in all these registers read back as zero.
`timescale 1ns/1ps
`include "flash_boost_regs.vh"
module flash_boost_status_ctrl_regs (
  input wire clock,
  input wire reset,
  input wire clockEnable,
  input wire [7:0] regAddr,
  input wire regWrite,
  input wire regRead,
  input wire [7:0] regWriteData,
  input wire peakLimitIn,
  input wire capCheckFailIn,
  input wire [7:0] adaptiveVoltageIn,
  input wire eventRequest,
  output reg [7:0] regReadData,
  output reg regReadValid,
  output reg [7:0] boostSoftstartLevel,
  output reg [3:0] indicatorLevelCode,
  output reg outputCapCheckOff,
  output reg eventBlocked,
  output reg eventGrant
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisation.

  wire peakLimitSync;
  wire capCheckFailSync;
  wire [7:0] adaptiveVoltageSync;

  input_sync #(
    .WIDTH(1),
    .RESET_VALUE(1'b0)
  ) peakSync (
    .clock(clock),
    .reset(reset),
    .clockEnable(clockEnable),
    .asyncIn(peakLimitIn),
    .syncOut(peakLimitSync)
  );

  input_sync #(
    .WIDTH(1),
    .RESET_VALUE(1'b0)
  ) capSync (
    .clock(clock),
    .reset(reset),
    .clockEnable(clockEnable),
    .asyncIn(capCheckFailIn),
    .syncOut(capCheckFailSync)
  );

  // The voltage code is synchronised bitwise; the converter must hold a new
  // code steady for at least three clocks or a mixed code may be seen once.
  input_sync #(
    .WIDTH(8),
    .RESET_VALUE(`RST_BOOST_VOLTAGE_MONITOR)
  ) voltSync (
    .clock(clock),
    .reset(reset),
    .clockEnable(clockEnable),
    .asyncIn(adaptiveVoltageIn),
    .syncOut(adaptiveVoltageSync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register state.

  reg peakLimitFlag_reg;
  reg capCheckError_reg;
  reg [7:0] voltageMonitor_reg;
  reg [7:0] peakVoltage_reg;

  // A read clears the flags only while the block is enabled, like all other state.
  wire statusRead = regRead && (regAddr == `ADDR_LINK_STATUS_FLAGS);
  wire capCheckEnabled = ~outputCapCheckOff;

  // A flag event in the same cycle as the clearing read wins over the clear.
  wire peakLimitFlag_next = peakLimitSync | (peakLimitFlag_reg & ~statusRead);
  wire capCheckError_next = (capCheckFailSync & capCheckEnabled) |
    (capCheckError_reg & ~statusRead);

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      peakLimitFlag_reg <= 1'b0;
      capCheckError_reg <= 1'b0;
      voltageMonitor_reg <= `RST_BOOST_VOLTAGE_MONITOR;
      peakVoltage_reg <= `RST_BOOST_PEAK_VOLTAGE_MONITOR;
    end else if (clockEnable) begin
      peakLimitFlag_reg <= peakLimitFlag_next;
      capCheckError_reg <= capCheckError_next;
      voltageMonitor_reg <= adaptiveVoltageSync;
      // The peak monitor is never cleared by a read, only by reset.
      if (adaptiveVoltageSync > peakVoltage_reg) begin
        peakVoltage_reg <= adaptiveVoltageSync;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software writes.

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      indicatorLevelCode <= 4'h0;
      boostSoftstartLevel <= `RST_BOOST_SOFTSTART_THRESHOLD;
      outputCapCheckOff <= `RST_CAP_CHECK_OFF;
    end else if (clockEnable && regWrite) begin
      // Only the defined fields are stored; the rest of the write word is dropped.
      case (regAddr)
        `ADDR_INDICATOR_LEVEL_CONTROL: begin
          indicatorLevelCode <= regWriteData[`INDICATOR_CODE_MSB:0];
        end
        `ADDR_BOOST_SOFTSTART_THRESHOLD: begin
          boostSoftstartLevel <= regWriteData;
        end
        `ADDR_CAP_CHECK_CONTROL: begin
          outputCapCheckOff <= regWriteData[`BIT_OUTPUT_CAP_CHECK_OFF];
        end
        default: begin
          // Status and monitor offsets are read-only; writes there do nothing.
          indicatorLevelCode <= indicatorLevelCode;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read words.

  // Each readable word with reserved bits is assembled field by field so that every reserved
  // range is tied to zero on its own line and cannot pick up a stray bit
  // when a field is added later.
  wire [7:0] statusWord;
  wire [7:0] indicatorWord;
  wire [7:0] capControlWord;

  assign statusWord[7] = 1'b0;
  assign statusWord[`BIT_PEAK_INPUT_LIMIT_FLAG] = peakLimitFlag_reg;
  assign statusWord[5] = 1'b0;
  assign statusWord[`BIT_OUTPUT_CAP_CHECK] = capCheckError_reg;
  assign statusWord[3:0] = 4'h0;
  assign indicatorWord[7:4] = 4'h0;
  assign indicatorWord[`INDICATOR_CODE_MSB:0] = indicatorLevelCode;
  assign capControlWord[7:4] = 4'h0;
  assign capControlWord[`BIT_OUTPUT_CAP_CHECK_OFF] = outputCapCheckOff;
  assign capControlWord[2:0] = 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Software reads.

  reg [7:0] readMux;

  always @* begin
    readMux = 8'h00;
    case (regAddr)
      `ADDR_LINK_STATUS_FLAGS: begin
        readMux = statusWord;
      end
      `ADDR_INDICATOR_LEVEL_CONTROL: begin
        readMux = indicatorWord;
      end
      `ADDR_BOOST_SOFTSTART_THRESHOLD: begin
        readMux = boostSoftstartLevel;
      end
      `ADDR_BOOST_VOLTAGE_MONITOR: begin
        readMux = voltageMonitor_reg;
      end
      `ADDR_BOOST_PEAK_VOLTAGE_MONITOR: begin
        readMux = peakVoltage_reg;
      end
      `ADDR_CAP_CHECK_CONTROL: begin
        readMux = capControlWord;
      end
      default: begin
        readMux = 8'h00;
      end
    endcase
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      regReadData <= 8'h00;
      regReadValid <= 1'b0;
    end else if (clockEnable) begin
      regReadValid <= regRead;
      // Read data holds between reads so the front end may fetch it late.
      if (regRead) begin
        regReadData <= readMux;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event gating.

  // The block tracks the error flag rather than a copy, so the read that
  // clears it also releases the block in the same edge.
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      eventBlocked <= 1'b0;
      eventGrant <= 1'b0;
    end else if (clockEnable) begin
      eventBlocked <= capCheckError_next;
      eventGrant <= eventRequest & ~capCheckError_reg;
    end
  end

endmodule // flash_boost_status_ctrl_regs

// ===== hw/flash_boost_regs.vh
// Register offsets, field positions and reset values for the flash boost register bank.
`ifndef FLASH_BOOST_REGS_VH
`define FLASH_BOOST_REGS_VH

`define ADDR_LINK_STATUS_FLAGS 8'h08
`define ADDR_INDICATOR_LEVEL_CONTROL 8'h0C
`define ADDR_BOOST_SOFTSTART_THRESHOLD 8'h20
`define ADDR_BOOST_VOLTAGE_MONITOR 8'h21
`define ADDR_BOOST_PEAK_VOLTAGE_MONITOR 8'h22
`define ADDR_CAP_CHECK_CONTROL 8'h23

`define RST_LINK_STATUS_FLAGS 8'h00
`define RST_INDICATOR_LEVEL_CONTROL 8'h00
`define RST_BOOST_SOFTSTART_THRESHOLD 8'h64
`define RST_BOOST_VOLTAGE_MONITOR 8'h84
`define RST_BOOST_PEAK_VOLTAGE_MONITOR 8'h00
`define RST_CAP_CHECK_OFF 1'b1

`define BIT_PEAK_INPUT_LIMIT_FLAG 6
`define BIT_OUTPUT_CAP_CHECK 4
`define BIT_OUTPUT_CAP_CHECK_OFF 3
`define INDICATOR_CODE_MSB 3

`define SYNC_STAGES 2

`endif

// ===== hw/input_sync.v
// Two-flop synchroniser for inputs arriving from the analog converter.
`timescale 1ns/1ps
module input_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
  input wire clock,
  input wire reset,
  input wire clockEnable,
  input wire [WIDTH-1:0] asyncIn,
  output reg [WIDTH-1:0] syncOut
);

  reg [WIDTH-1:0] stage1_reg;

  // Only the second stage reads the first one.
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      stage1_reg <= RESET_VALUE;
      syncOut <= RESET_VALUE;
    end else if (clockEnable) begin
      stage1_reg <= asyncIn;
      syncOut <= stage1_reg;
    end
  end

endmodule // input_sync

// ===== sim/flash_boost_regs_assertions.sv
// Port-level assertions for the flash boost register bank.
`timescale 1ns/1ps
module flash_boost_regs_assertions (
  input wire clock,
  input wire reset,
  input wire clockEnable,
  input wire [7:0] regAddr,
  input wire regWrite,
  input wire regRead,
  input wire [7:0] regWriteData,
  input wire eventRequest,
  input wire [7:0] regReadData,
  input wire regReadValid,
  input wire [7:0] boostSoftstartLevel,
  input wire [3:0] indicatorLevelCode,
  input wire outputCapCheckOff,
  input wire eventBlocked,
  input wire eventGrant
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  sequence s_wr(a); clockEnable && regWrite && regAddr == a; endsequence
  sequence s_rd(a); clockEnable && regRead && regAddr == a; endsequence
  property p_rdPulse; clockEnable && regRead |=> regReadValid; endproperty
  a_rdPulse: assert property (p_rdPulse) else $error("read gave no valid");
  property p_ss; s_wr(8'h20) |=> boostSoftstartLevel == $past(regWriteData); endproperty
  a_ss: assert property (p_ss) else $error("soft-start write lost");
  property p_ind; s_wr(8'h0C) |=> indicatorLevelCode == $past(regWriteData[3:0]); endproperty
  a_ind: assert property (p_ind) else $error("indicator write lost");
  property p_cap; s_wr(8'h23) |=> outputCapCheckOff == $past(regWriteData[3]); endproperty
  a_cap: assert property (p_cap) else $error("cap check write lost");
  property p_ssHold; !(regWrite && regAddr == 8'h20) |=> $stable(boostSoftstartLevel); endproperty
  a_ssHold: assert property (p_ssHold) else $error("soft-start changed");
  property p_noReq; clockEnable && !eventRequest |=> !eventGrant; endproperty
  a_noReq: assert property (p_noReq) else $error("grant without request");
  property p_block; clockEnable && eventBlocked && eventRequest |=> !eventGrant; endproperty
  a_block: assert property (p_block) else $error("grant while blocked");
  property p_rsv; s_rd(8'h0C) ##1 regReadValid |-> regReadData[7:4] == 4'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
endmodule // flash_boost_regs_assertions
bind flash_boost_status_ctrl_regs flash_boost_regs_assertions u_chk (
  .clock(clock),
  .reset(reset),
  .clockEnable(clockEnable),
  .regAddr(regAddr),
  .regWrite(regWrite),
  .regRead(regRead),
  .regWriteData(regWriteData),
  .eventRequest(eventRequest),
  .regReadData(regReadData),
  .regReadValid(regReadValid),
  .boostSoftstartLevel(boostSoftstartLevel),
  .indicatorLevelCode(indicatorLevelCode),
  .outputCapCheckOff(outputCapCheckOff),
  .eventBlocked(eventBlocked),
  .eventGrant(eventGrant)
);

// ===== sim/testbench.sv
// Self-checking testbench for the flash boost register bank.
`timescale 1ns/1ps
module testbench;
  reg clock = 0, reset = 1, regWrite = 0, regRead = 0, peakLimitIn = 0, capCheckFailIn = 0;
  reg eventRequest = 0, clockEnable = 1;
  reg [7:0] regAddr = 8'h00, regWriteData = 8'h00, adaptiveVoltageIn = 8'h84;
  wire [7:0] regReadData, boostSoftstartLevel;
  wire [3:0] indicatorLevelCode;
  wire regReadValid, outputCapCheckOff, eventBlocked, eventGrant;
  integer errorCnt = 0, totalChecks = 0;
  always #25 clock = ~clock;
  flash_boost_status_ctrl_regs u_flash_boost_status_ctrl_regs (.clock(clock), .reset(reset),
    .clockEnable(clockEnable), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
    .regWriteData(regWriteData), .peakLimitIn(peakLimitIn), .capCheckFailIn(capCheckFailIn),
    .adaptiveVoltageIn(adaptiveVoltageIn), .eventRequest(eventRequest),
    .regReadData(regReadData), .regReadValid(regReadValid),
    .boostSoftstartLevel(boostSoftstartLevel), .indicatorLevelCode(indicatorLevelCode),
    .outputCapCheckOff(outputCapCheckOff), .eventBlocked(eventBlocked), .eventGrant(eventGrant));
  ////////////////////////////////////////////////////////////////
  task chk(input [7:0] seen, input [7:0] exp);
    begin
      totalChecks = totalChecks + 1;
      if (seen !== exp) begin
        errorCnt = errorCnt + 1;
        $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // Inputs move 1 ns after the edge so the design never races the bench.
  task step(input integer n);
    begin
      repeat (n) @(posedge clock);
      #1;
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      step(1);
      regWrite = 1;
      regAddr = a;
      regWriteData = d;
      step(1);
      regWrite = 0;
    end
  endtask
  task rd(input [7:0] a, input [7:0] exp);
    begin
      step(1);
      regRead = 1;
      regAddr = a;
      step(1);
      regRead = 0;
      chk({7'h00, regReadValid}, 8'h01);
      chk(regReadData, exp);
    end
  endtask
  task results;
    begin
      if (errorCnt == 0 && totalChecks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////
  task t_writes;
    begin
      wr(8'h0C, 8'hFF);
      rd(8'h0C, 8'h0F);
      chk(indicatorLevelCode, 8'h0F);
      wr(8'h20, 8'hA5);
      chk(boostSoftstartLevel, 8'hA5);
      rd(8'h20, 8'hA5);
      wr(8'h21, 8'h11);
      wr(8'h08, 8'hFF);
      rd(8'h21, 8'h84);
      rd(8'h08, 8'h00);
      wr(8'h23, 8'hFF);
      rd(8'h23, 8'h08);
    end
  endtask
  task t_cap;
    begin
      capCheckFailIn = 1;
      step(4);
      rd(8'h08, 8'h00);
      wr(8'h23, 8'h00);
      chk({7'h00, outputCapCheckOff}, 8'h00);
      step(4);
      capCheckFailIn = 0;
      step(4);
      eventRequest = 1;
      step(1);
      eventRequest = 0;
      chk(eventGrant, 8'h00);
      chk({7'h00, eventBlocked}, 8'h01);
      rd(8'h08, 8'h10);
      eventRequest = 1;
      step(1);
      eventRequest = 0;
      chk(eventGrant, 8'h01);
      chk({7'h00, eventBlocked}, 8'h00);
    end
  endtask
  task t_peak;
    begin
      peakLimitIn = 1;
      step(4);
      peakLimitIn = 0;
      step(4);
      rd(8'h08, 8'h40);
      rd(8'h08, 8'h00);
    end
  endtask
  task t_volt;
    begin
      adaptiveVoltageIn = 8'h90;
      step(4);
      rd(8'h21, 8'h90);
      adaptiveVoltageIn = 8'h30;
      step(4);
      rd(8'h21, 8'h30);
      rd(8'h22, 8'h90);
    end
  endtask
  // With the enable low neither a write nor a read may touch any state.
  task t_freeze;
    begin
      step(1);
      clockEnable = 0;
      wr(8'h20, 8'h11);
      chk(boostSoftstartLevel, 8'hA5);
      step(1);
      regRead = 1;
      regAddr = 8'h20;
      step(1);
      regRead = 0;
      chk({7'h00, regReadValid}, 8'h00);
      clockEnable = 1;
      rd(8'h20, 8'hA5);
    end
  endtask
  task t_reset;
    begin
      reset = 1;
      step(2);
      chk(boostSoftstartLevel, 8'h64);
      chk({4'h0, indicatorLevelCode}, 8'h00);
      chk({7'h00, outputCapCheckOff}, 8'h01);
      chk({6'h00, eventBlocked, eventGrant}, 8'h00);
      reset = 0;
      rd(8'h20, 8'h64);
      rd(8'h0C, 8'h00);
      rd(8'h23, 8'h08);
      rd(8'h08, 8'h00);
    end
  endtask
  initial begin
    step(4);
    reset = 0;
    rd(8'h08, 8'h00);
    rd(8'h0C, 8'h00);
    rd(8'h20, 8'h64);
    rd(8'h21, 8'h84);
    rd(8'h23, 8'h08);
    rd(8'h30, 8'h00);
    t_writes;
    t_peak;
    t_cap;
    t_volt;
    t_freeze;
    t_reset;
    results;
  end
endmodule // testbench
